/* File: hw/arsa_pkg.sv */
// Package with constants shared by the rate adapter and scrambler files.
package arsa_pkg;
   localparam int unsigned CLK_HZ      = 40000000;
   localparam int unsigned LINE_BPS    = 1200;
   // Line bit period in clock cycles, rounded down.
   localparam int unsigned LINE_CYC    = CLK_HZ / LINE_BPS;
   // Terminal-side transmitter runs 1/90 of a bit faster.
   localparam int unsigned FAST_NUM    = 89;
   localparam int unsigned FAST_DEN    = 90;
   localparam int unsigned TERM_CYC    = (LINE_CYC * FAST_NUM) / FAST_DEN;
   localparam int unsigned CNT_W       = 16;
   localparam logic [CNT_W-1:0] LINE_CNT = CNT_W'(LINE_CYC - 1);
   localparam logic [CNT_W-1:0] TERM_CNT = CNT_W'(TERM_CYC - 1);
   localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(LINE_CYC / 2);
   localparam int unsigned HIST_W      = 17;
   localparam int unsigned TAP_A       = 14;
   localparam int unsigned TAP_B       = 17;
   localparam int unsigned GRP_CHARS   = 9;
   localparam logic [3:0]  GRP_LAST    = 4'(GRP_CHARS - 1);
   localparam logic [3:0]  BITS8       = 4'h8;
   localparam logic [3:0]  BITS7       = 4'h7;
   // Terminal frame steps: start, data, stop and one closing mark step.
   localparam logic [3:0]  TERM_SLOTS  = 4'hB;
   typedef enum {ST_IDLE, ST_START, ST_DATA, ST_STOP} arsa_tx_e;
endpackage

/* File: hw/arsa_scram.sv */
// Self-synchronising scrambler or descrambler with a 17-bit history.
`timescale 1ns/1ps
module arsa_scram
   import arsa_pkg::*;
#(
   parameter bit DESCRAMBLE = 1'b0
) (
   input  wire logic i_sys_clk,
   input  wire logic i_arst_n,
   input  wire logic i_step,
   input  wire logic i_bit,
   output logic      o_bit
);
   logic [HIST_W-1:0] hist_r;
   wire               mix_w;
   wire               hist_in_w;

   // Output mixes the input with taps 14 and 17 of the history.
   assign mix_w     = i_bit ^ hist_r[TAP_A-1] ^ hist_r[TAP_B-1];
   // Descrambler keeps line bits, scrambler keeps its own output.
   assign hist_in_w = DESCRAMBLE ? i_bit : mix_w;
   assign o_bit     = mix_w;

   // History shifts by one position per processed bit.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hist_r <= '0;
      end else if (i_step) begin
         hist_r <= {hist_r[HIST_W-2:0], hist_in_w};
      end
   end
endmodule

/* File: hw/arsa_top.sv */
// Async to sync rate adapter with scrambling toward the modem and back.
`timescale 1ns/1ps
module arsa_top
   import arsa_pkg::*;
(
   input  wire logic       i_sys_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_eight_bits,
   input  wire logic       i_term_rxd,
   input  wire logic [1:0] i_rx_dibit,
   input  wire logic       i_rx_dibit_vld,
   output logic            o_term_txd,
   output logic [1:0]      o_tx_dibit,
   output logic            o_tx_dibit_vld,
   output logic            o_stop_dropped
);
   // Terminal input resynchroniser: change counts when stages 2 and 3 agree.
   logic [2:0]       rxd_sync_r;
   logic             rxd_r;
   logic [CNT_W-1:0] line_cnt_r;
   logic             line_tick_r;
   logic [CNT_W-1:0] smp_cnt_r;
   logic             smp_busy_r;
   logic [3:0]       smp_idx_r;
   logic [8:0]       smp_sh_r;
   logic [9:0]       que_r;
   logic [3:0]       que_len_r;
   logic             que_pend_r;
   logic [3:0]       grp_cnt_r;
   logic             drop_ok_r;
   logic             tx_phase_r;
   logic             tx_first_r;
   logic [3:0]       nbits_w;

   assign nbits_w = i_eight_bits ? BITS8 : BITS7;

   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rxd_sync_r <= 3'h7;
         rxd_r      <= 1'b1;
      end else begin
         rxd_sync_r <= {rxd_sync_r[1:0], i_term_rxd};
         if (rxd_sync_r[1] == rxd_sync_r[2]) begin
            rxd_r <= rxd_sync_r[2];
         end
      end
   end

   // Line bit clock, one tick every LINE_CYC (33333) cycles, slightly above 1200 bit/s.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         line_cnt_r  <= '0;
         line_tick_r <= 1'b0;
      end else begin
         line_tick_r <= (line_cnt_r == LINE_CNT);
         line_cnt_r  <= (line_cnt_r == LINE_CNT) ? '0 : line_cnt_r + 1'b1;
      end
   end

   // Character sampler at the nominal rate, mid-bit sampling.
   wire smp_start_w = !smp_busy_r && !rxd_r;
   wire smp_hit_w   = smp_busy_r && (smp_cnt_r == '0);
   wire smp_done_w  = smp_hit_w && (smp_idx_r == nbits_w + 4'h1);
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         smp_busy_r <= 1'b0;
         smp_cnt_r  <= '0;
         smp_idx_r  <= '0;
         smp_sh_r   <= '0;
      end else if (smp_start_w) begin
         smp_busy_r <= 1'b1;
         smp_cnt_r  <= HALF_CNT;
         smp_idx_r  <= '0;
      end else if (smp_hit_w) begin
         smp_cnt_r <= LINE_CNT;
         smp_idx_r <= smp_idx_r + 4'h1;
         if (smp_idx_r != '0) begin
            smp_sh_r <= {rxd_r, smp_sh_r[8:1]};
         end
         if (smp_done_w || (smp_idx_r == '0 && rxd_r)) begin
            smp_busy_r <= 1'b0;
         end
      end else if (smp_busy_r) begin
         smp_cnt_r <= smp_cnt_r - 1'b1;
      end
   end

   // Character captured with its stop bit; 7-bit data is aligned low.
   // The stop bit is still on the line when the sampler finishes.
   wire [8:0] cap_w = i_eight_bits ? {rxd_r, smp_sh_r[8:1]}
                                   : {1'b0, rxd_r, smp_sh_r[8:2]};
   wire [9:0] frm_w = i_eight_bits ? {cap_w, 1'b0}
                                   : {1'b1, cap_w[7:0], 1'b0};
   wire       line_bit_w = que_pend_r ? que_r[0] : 1'b1;
   wire       que_last_w = (que_len_r == 4'h1);
   wire [3:0] frm_len_w  = nbits_w + 4'h2;
   // Queue is free when empty or when its last bit leaves on this tick.
   wire que_free_w = !que_pend_r || (que_last_w && line_tick_r);
   // A queued stop bit may be dropped when a new character waits.
   wire drop_w = que_pend_r && que_last_w && smp_done_w && cap_w[8]
                 && drop_ok_r && i_eight_bits && !line_tick_r;

   // Transmit queue: one frame, shifted out one bit per line tick.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         que_r          <= '1;
         que_len_r      <= '0;
         que_pend_r     <= 1'b0;
         grp_cnt_r      <= GRP_LAST;
         drop_ok_r      <= 1'b1;
         o_stop_dropped <= 1'b0;
      end else begin
         o_stop_dropped <= 1'b0;
         if (smp_done_w && (que_free_w || drop_w)) begin
            que_r      <= frm_w;
            que_len_r  <= frm_len_w;
            que_pend_r <= 1'b1;
            // Counts characters since the last deletion, so any nine
            // consecutive characters lose at most one stop bit.
            if (drop_w) begin
               grp_cnt_r      <= '0;
               drop_ok_r      <= 1'b0;
               o_stop_dropped <= 1'b1;
            end else if (grp_cnt_r != GRP_LAST) begin
               grp_cnt_r <= grp_cnt_r + 4'h1;
               drop_ok_r <= (grp_cnt_r == GRP_LAST - 4'h1);
            end
         end else if (line_tick_r && que_pend_r) begin
            que_r      <= {1'b1, que_r[9:1]};
            que_len_r  <= que_len_r - 4'h1;
            que_pend_r <= !que_last_w;
         end
      end
   end

   // Scrambler steps once per line bit.
   logic scr_out_w;
   arsa_scram #(.DESCRAMBLE(1'b0)) u_scr (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_step    (line_tick_r),
      .i_bit     (line_bit_w),
      .o_bit     (scr_out_w)
   );

   // Dibit packer: first bit in time goes to bit 1.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         tx_phase_r     <= 1'b0;
         tx_first_r     <= 1'b0;
         o_tx_dibit     <= '0;
         o_tx_dibit_vld <= 1'b0;
      end else begin
         o_tx_dibit_vld <= 1'b0;
         if (line_tick_r) begin
            tx_phase_r <= !tx_phase_r;
            if (!tx_phase_r) begin
               tx_first_r <= scr_out_w;
            end else begin
               o_tx_dibit     <= {tx_first_r, scr_out_w};
               o_tx_dibit_vld <= 1'b1;
            end
         end
      end
   end

   // Receive: dibit split into two serial bits, first bit first.
   logic       rx_half_r;
   logic       rx_lo_r;
   logic       rx_step_r;
   logic       rx_bit_r;
   logic       dsc_out_w;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rx_half_r <= 1'b0;
         rx_lo_r   <= 1'b0;
         rx_step_r <= 1'b0;
         rx_bit_r  <= 1'b0;
      end else begin
         rx_step_r <= i_rx_dibit_vld || rx_half_r;
         rx_half_r <= i_rx_dibit_vld;
         if (i_rx_dibit_vld) begin
            rx_bit_r <= i_rx_dibit[1];
            rx_lo_r  <= i_rx_dibit[0];
         end else if (rx_half_r) begin
            rx_bit_r <= rx_lo_r;
         end
      end
   end

   arsa_scram #(.DESCRAMBLE(1'b1)) u_dsc (
      .i_sys_clk (i_sys_clk),
      .i_arst_n  (i_arst_n),
      .i_step    (rx_step_r),
      .i_bit     (rx_bit_r),
      .o_bit     (dsc_out_w)
   );

   // Character assembler with stop-bit reinsertion.
   logic       asm_busy_r;
   logic [3:0] asm_idx_r;
   logic [8:0] asm_sh_r;
   logic [9:0] out_q_r;
   logic       out_full_r;
   wire asm_end_w = asm_busy_r && rx_step_r && (asm_idx_r == nbits_w);
   // Stop slot holding a start bit means the stop bit was deleted.
   wire miss_w    = asm_busy_r && rx_step_r && asm_idx_r == nbits_w
                    && !dsc_out_w;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         asm_busy_r <= 1'b0;
         asm_idx_r  <= '0;
         asm_sh_r   <= '0;
      end else if (rx_step_r) begin
         if (!asm_busy_r) begin
            asm_busy_r <= !dsc_out_w;
            asm_idx_r  <= '0;
         end else if (asm_end_w) begin
            asm_busy_r <= miss_w;
            asm_idx_r  <= '0;
         end else begin
            asm_sh_r  <= {dsc_out_w, asm_sh_r[8:1]};
            asm_idx_r <= asm_idx_r + 4'h1;
         end
      end
   end

   // Terminal transmitter, one ninetieth fast; frame always has its stop.
   // The waiting frame and the frame being shifted are kept apart, so a
   // new character cannot overwrite the one still going out.
   wire [7:0] rdat_w = i_eight_bits ? asm_sh_r[8:1] : {1'b1, asm_sh_r[8:2]};
   logic [CNT_W-1:0] term_cnt_r;
   logic [3:0]       term_left_r;
   logic [9:0]       term_sh_r;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         out_q_r     <= '1;
         out_full_r  <= 1'b0;
         term_cnt_r  <= '0;
         term_left_r <= '0;
         term_sh_r   <= '1;
         o_term_txd  <= 1'b1;
      end else begin
         if (asm_end_w && !out_full_r) begin
            out_q_r    <= {1'b1, rdat_w, 1'b0};
            out_full_r <= 1'b1;
         end
         if (term_left_r != '0) begin
            if (term_cnt_r == '0) begin
               term_cnt_r  <= TERM_CNT;
               term_left_r <= term_left_r - 4'h1;
               o_term_txd  <= (term_left_r == 4'h1) ? 1'b1 : term_sh_r[0];
               term_sh_r   <= {1'b1, term_sh_r[9:1]};
            end else begin
               term_cnt_r <= term_cnt_r - 1'b1;
            end
         end else if (out_full_r && !(asm_end_w)) begin
            term_left_r <= TERM_SLOTS;
            term_cnt_r  <= '0;
            term_sh_r   <= out_q_r;
            out_full_r  <= 1'b0;
         end
      end
   end
endmodule

/* File: tb/arsa_chk.sv */
// Port checker for the rate adapter and scrambler top.
`timescale 1ns/1ps
module arsa_chk
   import arsa_pkg::*;
(
   input wire logic       i_sys_clk,
   input wire logic       i_arst_n,
   input wire logic       i_eight_bits,
   input wire logic       i_term_rxd,
   input wire logic [1:0] i_rx_dibit,
   input wire logic       i_rx_dibit_vld,
   input wire logic       o_term_txd,
   input wire logic [1:0] o_tx_dibit,
   input wire logic       o_tx_dibit_vld,
   input wire logic       o_stop_dropped
);
   localparam int GAP = 2 * LINE_CYC - 1;
   localparam int LOWMAX = 9 * TERM_CYC;
   localparam int DGAP = 72 * LINE_CYC;
   int   gap_r;
   int   low_r;
   int   drp_r;
   logic seen_r;
   logic dseen_r;
   // Cycles since the last dibit, since the line fell, since a drop.
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         {gap_r, low_r, drp_r, seen_r, dseen_r} <= '0;
      end else begin
         gap_r <= o_tx_dibit_vld ? 0 : gap_r + 1;
         low_r <= o_term_txd ? 0 : low_r + 1;
         drp_r <= o_stop_dropped ? 0 : drp_r + 1;
         seen_r <= seen_r | o_tx_dibit_vld;
         dseen_r <= dseen_r | o_stop_dropped;
      end
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   // Line-side strobe and dibit timing.
   vld_pulse_a: assert property (o_tx_dibit_vld |=> !o_tx_dibit_vld)
      else $error("dibit strobe longer than one cycle");
   dibit_hold_a: assert property (!o_tx_dibit_vld |-> $stable(o_tx_dibit))
      else $error("dibit changed without strobe");
   vld_gap_a: assert property (o_tx_dibit_vld && seen_r |-> gap_r == GAP)
      else $error("dibit spacing is not two line bits");
   gap_max_a: assert property (gap_r <= GAP + 3)
      else $error("line stream stalled");
   // Stop deletion limits.
   drop_pulse_a: assert property (o_stop_dropped |=> !o_stop_dropped)
      else $error("drop pulse longer than one cycle");
   drop_mode_a: assert property (o_stop_dropped |-> i_eight_bits)
      else $error("stop dropped in seven bit mode");
   drop_gap_a: assert property (o_stop_dropped && dseen_r |-> drp_r >= DGAP)
      else $error("stop drops too close together");
   // Terminal-side bit timing.
   txd_bit_a: assert property ($rose(o_term_txd) |-> low_r % TERM_CYC == 0)
      else $error("terminal low run not whole bits");
   txd_low_a: assert property (low_r <= LOWMAX)
      else $error("terminal line low too long");
   vld_c: cover property (o_tx_dibit_vld && seen_r);
   txd_c: cover property ($rose(o_term_txd));
   drop_c: cover property (o_stop_dropped);
endmodule
bind arsa_top arsa_chk arsa_chk_i (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
   .i_eight_bits(i_eight_bits), .i_term_rxd(i_term_rxd),
   .i_rx_dibit(i_rx_dibit), .i_rx_dibit_vld(i_rx_dibit_vld),
   .o_term_txd(o_term_txd), .o_tx_dibit(o_tx_dibit),
   .o_tx_dibit_vld(o_tx_dibit_vld), .o_stop_dropped(o_stop_dropped));

/* File: tb/arsa_modem_model.sv */
// Demodulator model that scrambles bits and hands over dibits.
`timescale 1ns/1ps
module arsa_modem_model
   import arsa_pkg::*;
(
   input  wire logic       i_sys_clk,
   output logic [1:0]      o_dibit,
   output logic            o_dibit_vld
);
   logic [HIST_W-1:0] hist;
   // Starts with a cleared history, as the receiver does.
   initial begin
      o_dibit = 2'h0;
      o_dibit_vld = 1'h0;
      hist = '0;
   end
   // Scrambles one bit; hist[0] holds the newest output.
   function automatic logic scr(input logic d);
      logic s;
      s = d ^ hist[TAP_A-1] ^ hist[TAP_B-1];
      hist = {hist[HIST_W-2:0], s};
      return s;
   endfunction
   // Sends n bits, LSB first, two per strobe, two cycles apart.
   task automatic send_bits(input logic [15:0] bits, input int n);
      logic a;
      logic b;
      for (int k = 0; k < n; k += 2) begin
         a = scr(bits[k]);
         b = scr(bits[k+1]);
         o_dibit <= {a, b};
         o_dibit_vld <= 1'h1;
         @(posedge i_sys_clk);
         o_dibit <= ~{a, b};
         o_dibit_vld <= 1'h0;
         @(posedge i_sys_clk);
      end
   endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the rate adapter and scrambler.
`timescale 1ns/1ps
module tb_top;
   import arsa_pkg::*;
   logic        i_sys_clk;
   logic        i_arst_n;
   logic        i_eight_bits;
   logic        i_term_rxd;
   logic [1:0]  rx_dibit;
   logic        rx_vld;
   logic        o_term_txd;
   logic [1:0]  o_tx_dibit;
   logic        o_tx_dibit_vld;
   logic        o_stop_dropped;
   logic [1:0]  exp_dib[$];
   logic        exp_txd[$];
   int          num_errors;
   int          checked;
   logic [31:0] seed;
   logic [7:0]  data;
   arsa_top arsa_top_i (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n),
      .i_eight_bits(i_eight_bits), .i_term_rxd(i_term_rxd),
      .i_rx_dibit(rx_dibit), .i_rx_dibit_vld(rx_vld),
      .o_term_txd(o_term_txd), .o_tx_dibit(o_tx_dibit),
      .o_tx_dibit_vld(o_tx_dibit_vld), .o_stop_dropped(o_stop_dropped));
   arsa_modem_model arsa_modem_model_i (.i_sys_clk(i_sys_clk),
      .o_dibit(rx_dibit), .o_dibit_vld(rx_vld));
   // Makes the 40 MHz clock.
   initial begin
      i_sys_clk = 1'h0;
      forever #12.5 i_sys_clk = ~i_sys_clk;
   end
   // Steps the pseudo-random generator.
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // Compares a line dibit with the oldest note.
   task automatic chk_dibit(input logic [1:0] seen);
      logic [1:0] exp;
      exp = exp_dib.pop_front();
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED tx_dibit expected %b seen %b", exp, seen);
      end
   endtask
   // Compares a terminal bit with the oldest note.
   task automatic chk_txd(input logic seen);
      logic exp;
      exp = exp_txd.pop_front();
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED term_txd expected %b seen %b", exp, seen);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("Counts: %0d checks, %0d mismatches", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Resets, notes expectations and sends one framed character.
   initial begin
      {i_arst_n, num_errors, checked} = '0;
      {i_eight_bits, i_term_rxd} = 2'h3;
      seed = 32'hBEE931F3;
      repeat (5) @(posedge i_sys_clk);
      i_arst_n <= 1'h1;
      @(posedge i_sys_clk);
      // A line bit lasts 33333 cycles and a terminal bit 32962, so the run
      // checks one line dibit and the first three terminal bits.
      exp_dib.push_back(2'h3);
      seed = xorshift(seed);
      data = seed[7:0] | 8'h01;
      exp_txd.push_back(1'h0);
      for (int k = 0; k < 2; k++) exp_txd.push_back(data[k]);
      // Sixteen marks first, so tap 14 carries a one and tap 17 still a zero.
      arsa_modem_model_i.send_bits(16'hFFFF, 16);
      arsa_modem_model_i.send_bits({4'hF, 1'h1, data, 1'h0, 2'h3}, 12);
      for (int c = 0; c < 90000 && exp_dib.size() + exp_txd.size() > 0;
           c++) @(posedge i_sys_clk);
      if (exp_dib.size() + exp_txd.size() > 0) begin
         num_errors++;
         $display("CHECK FAILED run expected done seen pending");
      end
      give_verdict();
   end
   // Checks each strobed dibit of the idle mark stream.
   always @(posedge i_sys_clk) begin
      if (o_tx_dibit_vld === 1'h1) begin
         chk_dibit(o_tx_dibit);
         if (exp_dib.size() == 0) $display("Test idle marks done");
      end
   end
   // Samples the first three bits of the returned character at the middle of each bit.
   initial begin
      int n;
      n = 0;
      wait (i_arst_n === 1'h1);
      while (o_term_txd !== 1'h0 && n < 20000) begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n >= 20000) begin
         num_errors++;
         $display("CHECK FAILED term_txd expected start seen none");
      end
      repeat (TERM_CYC / 2) @(posedge i_sys_clk);
      for (int k = 0; k < 3; k++) begin
         chk_txd(o_term_txd);
         if (k < 2) repeat (TERM_CYC) @(posedge i_sys_clk);
      end
      $display("Test returned character done");
   end
endmodule
